// File: logic/dpcfg_pkg.sv
// Purpose: Shared constants for the datapath mode configuration bank
// Assumes: Register index times four gives the AXI byte address
// Notes: Indexes are word indexes, not byte addresses
package dpcfg_pkg;
  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_PAGE = 10'h008;
  localparam logic [9:0] IDX_HOLD = 10'h100;
  localparam logic [9:0] IDX_LINK = 10'h110;
  localparam logic [9:0] IDX_INTERP = 10'h111;
  localparam logic [9:0] IDX_NCO = 10'h112;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h200;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h201;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned HOLD_BIT = 0;
  localparam int unsigned INVALID_BIT = 7;
  localparam int unsigned COMBINE_BIT = 6;
  localparam int unsigned DUAL_BIT = 5;
  localparam int unsigned MAIN_LSB = 4;
  localparam int unsigned SW_LSB = 4;
  localparam int unsigned NCO_EN_BIT = 3;
  localparam int unsigned FRAC_BIT = 2;
  localparam int unsigned SB_BIT = 1;
  localparam int unsigned EV_INVALID = 0;
  localparam int unsigned EV_RELEASE = 1;
  localparam int unsigned NUM_EV = 2;
  // ----------------------------------------------------------------
  // Reset values and AXI response codes
  // ----------------------------------------------------------------
  localparam logic HOLD_RST = 1'b1;
  localparam logic [5:0] LINK_RST = 6'h20;
  localparam logic [3:0] MAIN_RST = 4'h8;
  localparam logic [3:0] CHAN_RST = 4'h4;
  localparam logic [4:0] NCO_RST = 5'h00;
  localparam logic [1:0] PAGE_RST = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Modulator switch modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPCFG_SW_SPLIT = 2'h0,
    DPCFG_SW_SUM_IQ = 2'h1,
    DPCFG_SW_IQ0 = 2'h2,
    DPCFG_SW_SUM_ZERO = 2'h3
  } dpcfg_sw_t;
endpackage : dpcfg_pkg

// File: logic/dpcfg_combo_chk.sv
// Purpose: Flags unsupported link mode and interpolation combinations
// Assumes: Inputs come from registers on the same clock
// Notes: Only the coarse legality checks are modelled here
`timescale 1ns/1ns
module dpcfg_combo_chk #(
  parameter logic [4:0] MAX_MODE = 5'h13
) (
  // Programmed settings
  input wire logic [5:0] i_link_mode,
  input wire logic [3:0] i_main,
  input wire logic [3:0] i_chan,
  // Verdict
  output logic o_bad
);
  logic main_ok;
  logic chan_ok;
  logic mode_ok;
  logic bypass_ok;
  assign main_ok = i_main inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hc};
  assign chan_ok = i_chan inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
  assign mode_ok = i_link_mode[4:0] <= MAX_MODE;
  // A bypassed main path cannot carry channel interpolation
  assign bypass_ok = (i_main != 4'h1) || (i_chan == 4'h1);
  assign o_bad = !(main_ok && chan_ok && mode_ok && bypass_ok);
endmodule : dpcfg_combo_chk

// File: logic/dpcfg_mod_switch.sv
// Purpose: Routes I and Q streams onto the two DAC outputs
// Assumes: Samples are two's complement on the register clock
// Notes: Sums wrap; the caller keeps headroom
`timescale 1ns/1ns
module dpcfg_mod_switch #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_hold,
  input wire logic [1:0] i_mode,
  input wire logic i_lower_sb,
  // Samples in
  input wire logic [W-1:0] i_i0,
  input wire logic [W-1:0] i_i1,
  input wire logic [W-1:0] i_q0,
  input wire logic [W-1:0] i_q1,
  // Samples out
  output logic [W-1:0] o_dac0,
  output logic [W-1:0] o_dac1
);
  logic [W-1:0] q0;
  logic [W-1:0] q1;
  logic [W-1:0] sum_i;
  logic [W-1:0] sum_q;
  logic [W-1:0] d0_nxt;
  logic [W-1:0] d1_nxt;
  // Lower sideband flips the spectrum by negating quadrature
  assign q0 = i_lower_sb ? W'(-i_q0) : i_q0;
  assign q1 = i_lower_sb ? W'(-i_q1) : i_q1;
  assign sum_i = W'(i_i0 + i_i1);
  assign sum_q = W'(q0 + q1);
  always_comb begin
    d0_nxt = i_i0;
    d1_nxt = i_i1;
    unique case (dpcfg_pkg::dpcfg_sw_t'(i_mode))
      dpcfg_pkg::DPCFG_SW_SPLIT: begin
        d0_nxt = i_i0;
        d1_nxt = i_i1;
      end
      dpcfg_pkg::DPCFG_SW_SUM_IQ: begin
        d0_nxt = sum_i;
        d1_nxt = sum_q;
      end
      dpcfg_pkg::DPCFG_SW_IQ0: begin
        d0_nxt = i_i0;
        d1_nxt = q0;
      end
      dpcfg_pkg::DPCFG_SW_SUM_ZERO: begin
        d0_nxt = sum_i;
        d1_nxt = '0;
      end
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_hold) begin
      o_dac0 <= '0;
      o_dac1 <= '0;
    end else begin
      o_dac0 <= d0_nxt;
      o_dac1 <= d1_nxt;
    end
  end
endmodule : dpcfg_mod_switch

// File: logic/dpcfg_top.sv
// Purpose: AXI4-Lite register bank for datapath mode and main NCO setup
// Assumes: Single clock; link sync requests come from same-clock logic
// Notes: Byte address is four times the register index
`timescale 1ns/1ns
module dpcfg_top #(
  parameter int unsigned NP = 2,
  parameter int unsigned W = 16,
  parameter logic [4:0] MAX_MODE = 5'h13
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Link sync
  input wire logic [1:0] i_sync_req_n,
  output logic [1:0] o_sync_out_n,
  // Samples
  input wire logic [W-1:0] i_i0,
  input wire logic [W-1:0] i_i1,
  input wire logic [W-1:0] i_q0,
  input wire logic [W-1:0] i_q1,
  output logic [W-1:0] o_dac0,
  output logic [W-1:0] o_dac1,
  // Configuration out
  output logic o_datapath_rst,
  output logic o_link_dual,
  output logic [4:0] o_link_mode_sel,
  output logic [3:0] o_main_interp,
  output logic [3:0] o_chan_interp,
  output logic [NP-1:0] o_nco_en,
  output logic [NP-1:0] o_frac_dds_en,
  output logic [NP-1:0] o_sideband_low,
  output logic [2*NP-1:0] o_switch_mode,
  // Interrupt
  output logic o_irq
);
  // Assertions below share this clock and reset
  default clocking dpcfg_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic aw_have_r, w_have_r, wstrb0_r;
  logic [9:0] aw_idx_r;
  logic [31:0] wdata_r, rdata_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic hold_r, combine_r, invalid_r;
  logic [5:0] link_r;
  logic [7:0] interp_r;
  logic [1:0] page_r, sync_r;
  logic [4:0] nco_r [NP];
  logic [dpcfg_pkg::NUM_EV-1:0] stat_r, mask_r;
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_go, wr_lo, ar_go;
  logic [9:0] ar_idx;
  logic wr_hold, wr_link, wr_interp, wr_nco;
  logic wr_page, wr_stat, wr_mask;
  logic wr_known, rd_known, combo_bad, hold_nxt;
  logic [4:0] nco_rd;
  logic [7:0] rd_val;
  logic [dpcfg_pkg::NUM_EV-1:0] ev, stat_nxt;
  assign o_awready = !aw_have_r;
  assign o_wready = !w_have_r;
  assign o_arready = !rvalid_r;
  assign wr_go = aw_have_r && w_have_r && !bvalid_r;
  assign wr_lo = wr_go && wstrb0_r;
  assign ar_go = i_arvalid && !rvalid_r;
  assign ar_idx = i_araddr[11:2];
  assign wr_hold = wr_lo && aw_idx_r == dpcfg_pkg::IDX_HOLD;
  assign wr_link = wr_lo && aw_idx_r == dpcfg_pkg::IDX_LINK;
  assign wr_interp = wr_lo && aw_idx_r == dpcfg_pkg::IDX_INTERP;
  assign wr_nco = wr_lo && aw_idx_r == dpcfg_pkg::IDX_NCO;
  assign wr_page = wr_lo && aw_idx_r == dpcfg_pkg::IDX_PAGE;
  assign wr_stat = wr_lo && aw_idx_r == dpcfg_pkg::IDX_IRQ_STAT;
  assign wr_mask = wr_lo && aw_idx_r == dpcfg_pkg::IDX_IRQ_MASK;
  assign wr_known = aw_idx_r inside {dpcfg_pkg::IDX_HOLD,
    dpcfg_pkg::IDX_LINK, dpcfg_pkg::IDX_INTERP, dpcfg_pkg::IDX_NCO,
    dpcfg_pkg::IDX_PAGE, dpcfg_pkg::IDX_IRQ_STAT,
    dpcfg_pkg::IDX_IRQ_MASK};
  assign rd_known = ar_idx inside {dpcfg_pkg::IDX_HOLD,
    dpcfg_pkg::IDX_LINK, dpcfg_pkg::IDX_INTERP, dpcfg_pkg::IDX_NCO,
    dpcfg_pkg::IDX_PAGE, dpcfg_pkg::IDX_IRQ_STAT,
    dpcfg_pkg::IDX_IRQ_MASK};
  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_idx_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= dpcfg_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_idx_r <= i_awaddr[11:2];
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (i_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb0_r <= i_wstrb[0];
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? dpcfg_pkg::RESP_OKAY
                            : dpcfg_pkg::RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // hold release
  assign hold_nxt = wr_hold ? wdata_r[dpcfg_pkg::HOLD_BIT] : hold_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      hold_r <= dpcfg_pkg::HOLD_RST;
      combine_r <= 1'b0;
      link_r <= dpcfg_pkg::LINK_RST;
      interp_r <= {dpcfg_pkg::MAIN_RST, dpcfg_pkg::CHAN_RST};
      page_r <= dpcfg_pkg::PAGE_RST;
    end else begin
      hold_r <= hold_nxt;
      if (wr_link) begin
        combine_r <= wdata_r[dpcfg_pkg::COMBINE_BIT];
        link_r <= wdata_r[5:0];
      end
      if (wr_interp) begin
        interp_r <= wdata_r[7:0];
      end
      if (wr_page) begin
        page_r <= wdata_r[1:0];
      end
    end
  end
  for (genvar p = 0; p < NP; p++) begin : g_path
    always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
        nco_r[p] <= dpcfg_pkg::NCO_RST;
      end else if (wr_nco && page_r[p % 2]) begin
        nco_r[p] <= wdata_r[5:1];
      end
    end
    assign o_nco_en[p] = nco_r[p][dpcfg_pkg::NCO_EN_BIT-1];
    assign o_frac_dds_en[p] = nco_r[p][dpcfg_pkg::FRAC_BIT-1];
    assign o_sideband_low[p] = nco_r[p][dpcfg_pkg::SB_BIT-1];
    assign o_switch_mode[2*p+:2] = nco_r[p][4:3];
  end
  // Lowest selected page answers a read
  assign nco_rd = page_r[0] ? nco_r[0] : (page_r[1] ? nco_r[NP-1] : '0);
  // ----------------------------------------------------------------
  // Combination check and interrupts
  // ----------------------------------------------------------------
  dpcfg_combo_chk #(
    .MAX_MODE(MAX_MODE)
  ) u_chk (
    .i_link_mode(link_r),
    .i_main(interp_r[7:4]),
    .i_chan(interp_r[3:0]),
    .o_bad(combo_bad)
  );
  // release after lock is software's duty; event marks it
  assign ev[dpcfg_pkg::EV_INVALID] = combo_bad && !invalid_r;
  assign ev[dpcfg_pkg::EV_RELEASE] = hold_r && !hold_nxt;
  // Set wins over a simultaneous write-one clear
  assign stat_nxt = (stat_r & ~(wr_stat ? wdata_r[1:0] : 2'h0)) | ev;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      invalid_r <= 1'b0;
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      invalid_r <= combo_bad;
      stat_r <= stat_nxt;
      if (wr_mask) begin
        mask_r <= wdata_r[1:0];
      end
    end
  end
  assign o_irq = |(stat_r & mask_r);
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    unique case (ar_idx)
      dpcfg_pkg::IDX_HOLD: rd_val = {7'h00, hold_r};
      dpcfg_pkg::IDX_LINK: rd_val = {invalid_r, combine_r, link_r};
      dpcfg_pkg::IDX_INTERP: rd_val = interp_r;
      dpcfg_pkg::IDX_NCO: rd_val = {2'h0, nco_rd, 1'b0};
      dpcfg_pkg::IDX_PAGE: rd_val = {6'h00, page_r};
      dpcfg_pkg::IDX_IRQ_STAT: rd_val = {6'h00, stat_r};
      dpcfg_pkg::IDX_IRQ_MASK: rd_val = {6'h00, mask_r};
      default: rd_val = 8'h00;
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= dpcfg_pkg::RESP_OKAY;
    end else if (ar_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_val};
      rresp_r <= rd_known ? dpcfg_pkg::RESP_OKAY
                          : dpcfg_pkg::RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  // ----------------------------------------------------------------
  // Link and datapath outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sync_r <= 2'h3;
    end else if (combine_r && link_r[dpcfg_pkg::DUAL_BIT]) begin
      sync_r <= {2{&i_sync_req_n}};
    end else begin
      sync_r <= i_sync_req_n;
    end
  end
  assign o_sync_out_n = sync_r;
  assign o_datapath_rst = hold_r;
  assign o_link_dual = link_r[dpcfg_pkg::DUAL_BIT];
  assign o_link_mode_sel = link_r[4:0];
  assign o_main_interp = interp_r[7:4];
  assign o_chan_interp = interp_r[3:0];
  dpcfg_mod_switch #(
    .W(W)
  ) u_sw (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_hold(hold_r),
    .i_mode(nco_r[0][4:3]),
    .i_lower_sb(nco_r[0][0]),
    .i_i0(i_i0),
    .i_i1(i_i1),
    .i_q0(i_q0),
    .i_q1(i_q1),
    .o_dac0(o_dac0),
    .o_dac1(o_dac1)
  );
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hold;
    o_datapath_rst |=> (o_dac0 == '0 && o_dac1 == '0);
  endproperty
  a_hold: assert property (p_hold) else $error("dac out in hold");
  property p_invalid;
    ##1 invalid_r == $past(combo_bad);
  endproperty
  a_invalid: assert property (p_invalid) else $error("flag lag");
  property p_combine;
    (combine_r && o_link_dual && !i_sync_req_n[1]) |=> !o_sync_out_n[0];
  endproperty
  a_combine: assert property (p_combine) else $error("no merge");
  property p_dual;
    wr_link |=> o_link_dual == $past(wdata_r[5]);
  endproperty
  a_dual: assert property (p_dual) else $error("dual bit");
  property p_lane;
    wr_link |=> o_link_mode_sel == $past(wdata_r[4:0]);
  endproperty
  a_lane: assert property (p_lane) else $error("lane mode");
  property p_main;
    wr_interp |=> o_main_interp == $past(wdata_r[7:4]);
  endproperty
  a_main: assert property (p_main) else $error("main rate");
  property p_chan;
    wr_interp |=> o_chan_interp == $past(wdata_r[3:0]);
  endproperty
  a_chan: assert property (p_chan) else $error("chan rate");
  property p_zero;
    (o_switch_mode[1:0] == 2'h3) |=> o_dac1 == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("dac1 not zero");
  property p_page;
    (wr_nco && !page_r[0]) |=> $stable(nco_r[0]);
  endproperty
  a_page: assert property (p_page) else $error("unpaged write");
  property p_en;
    (wr_nco && page_r[0]) |=> o_nco_en[0] == $past(wdata_r[3]);
  endproperty
  a_en: assert property (p_en) else $error("nco enable");
  property p_frac;
    (wr_nco && page_r[0]) |=> o_frac_dds_en[0] == $past(wdata_r[2]);
  endproperty
  a_frac: assert property (p_frac) else $error("frac dds");
  property p_upper;
    (wr_nco && page_r[0] && !wdata_r[1]) |=> !o_sideband_low[0];
  endproperty
  a_upper: assert property (p_upper) else $error("upper sb");
  property p_lower;
    (wr_nco && page_r[0] && wdata_r[1]) |=> o_sideband_low[0];
  endproperty
  a_lower: assert property (p_lower) else $error("lower sb");
  property p_resv;
    (ar_go && ar_idx == dpcfg_pkg::IDX_HOLD) |=> o_rdata[31:1] == '0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
endmodule : dpcfg_top

// File: tb/dpcfg_top_test.sv
// Purpose: Self-checking bench for the datapath mode register bank
// Assumes: AXI4-Lite master tasks; byte address is four times the index
// Notes: Expected values come from the register map, not from the design
`timescale 1ns/1ns
module dpcfg_top_test;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [1:0] sync_n = 2'h3;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp, o_sync_out_n;
  logic [31:0] o_rdata;
  logic [15:0] o_dac0, o_dac1;
  logic o_datapath_rst, o_link_dual;
  logic [4:0] o_link_mode_sel;
  logic [3:0] o_main_interp, o_chan_interp, o_switch_mode;
  logic [1:0] o_nco_en, o_frac_dds_en, o_sideband_low;
  logic [1:0] resp;
  logic [31:0] rdat;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  localparam logic [15:0] I0 = 16'h0001;
  localparam logic [15:0] I1 = 16'h0002;
  localparam logic [15:0] Q0 = 16'h0003;
  localparam logic [15:0] Q1 = 16'h0004;

  dpcfg_top DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n),
    .i_awvalid(awvalid), .o_awready(o_awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(o_wready), .i_wdata(wdata),
    .i_wstrb(4'hf), .o_bvalid(o_bvalid), .i_bready(bready),
    .o_bresp(o_bresp), .i_arvalid(arvalid), .o_arready(o_arready),
    .i_araddr(araddr), .o_rvalid(o_rvalid), .i_rready(rready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .i_sync_req_n(sync_n),
    .o_sync_out_n(o_sync_out_n), .i_i0(I0), .i_i1(I1), .i_q0(Q0),
    .i_q1(Q1), .o_dac0(o_dac0), .o_dac1(o_dac1),
    .o_datapath_rst(o_datapath_rst), .o_link_dual(o_link_dual),
    .o_link_mode_sel(o_link_mode_sel), .o_main_interp(o_main_interp),
    .o_chan_interp(o_chan_interp), .o_nco_en(o_nco_en),
    .o_frac_dds_en(o_frac_dds_en), .o_sideband_low(o_sideband_low),
    .o_switch_mode(o_switch_mode), .o_irq(o_irq)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Verdict, compares and bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Cut a hang short; the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t: response %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  // Address and data offered together, each released when taken
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && o_awready) awvalid <= 1'b0;
      if (wvalid && o_wready) wvalid <= 1'b0;
      if (bready && o_bvalid) begin
        resp = o_bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && o_arready) arvalid <= 1'b0;
      if (rready && o_rvalid) begin
        rdat = o_rdata;
        resp = o_rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    rd(idx);
    chk_val(rdat, exp);
  endtask : rd_chk

  // Margin past the one-cycle register latencies, sampled mid-cycle
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  logic [7:0] lk [9] = '{8'h20, 8'h05, 8'h05, 8'hb3, 8'h34, 8'h13,
                         8'h13, 8'h40, 8'h01};
  logic [7:0] ip [9] = '{8'h84, 8'h11, 8'h12, 8'hc8, 8'h26, 8'h34,
                         8'h65, 8'h68, 8'h43};
  logic bad [9] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0] lk_s [3] = '{8'h60, 8'h20, 8'h40};
  logic [1:0] sy_s [3] = '{2'b00, 2'b01, 2'b01};
  logic [15:0] q0e, q1e, e0, e1;

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_val({17'h0, o_datapath_rst, o_link_dual, o_link_mode_sel,
      o_main_interp, o_chan_interp}, 32'h6084);
    chk_val({21'h0, o_nco_en, o_frac_dds_en, o_sideband_low,
      o_switch_mode, o_irq}, 32'h0);
    chk_val({o_dac0, o_dac1}, 32'h0);
    rd_chk(dpcfg_pkg::IDX_HOLD, 32'h01);
    rd_chk(dpcfg_pkg::IDX_LINK, 32'h20);
    rd_chk(dpcfg_pkg::IDX_INTERP, 32'h84);
    rd_chk(dpcfg_pkg::IDX_NCO, 32'h00);
    // Clocks count as locked here, so the hold may be released
    wr(dpcfg_pkg::IDX_HOLD, 32'hfe);
    chk_resp(resp, dpcfg_pkg::RESP_OKAY);
    rd_chk(dpcfg_pkg::IDX_HOLD, 32'h00);
    rd_chk(dpcfg_pkg::IDX_IRQ_STAT, 32'h2);
    chk_val({31'h0, o_datapath_rst | o_irq}, 32'h0);
    wr(dpcfg_pkg::IDX_IRQ_MASK, 32'h2);
    settle();
    chk_val({31'h0, o_irq}, 32'h1);
    wr(dpcfg_pkg::IDX_IRQ_STAT, 32'h2);
    rd_chk(dpcfg_pkg::IDX_IRQ_STAT, 32'h0);
    chk_val({31'h0, o_irq}, 32'h0);
    for (int k = 0; k < 9; k++) begin
      wr(dpcfg_pkg::IDX_INTERP, {24'h0, ip[k]});
      wr(dpcfg_pkg::IDX_LINK, {24'h0, lk[k]});
      rd_chk(dpcfg_pkg::IDX_LINK, {24'h0, bad[k], lk[k][6:0]});
      rd_chk(dpcfg_pkg::IDX_INTERP, {24'h0, ip[k]});
      chk_val({18'h0, o_link_dual, o_link_mode_sel, o_main_interp,
        o_chan_interp}, {18'h0, lk[k][5:0], ip[k]});
    end
    rd_chk(dpcfg_pkg::IDX_IRQ_STAT, 32'h1);
    wr(dpcfg_pkg::IDX_IRQ_MASK, 32'h3);
    settle();
    chk_val({31'h0, o_irq}, 32'h1);
    wr(dpcfg_pkg::IDX_IRQ_STAT, 32'h3);
    settle();
    chk_val({31'h0, o_irq}, 32'h0);
    wr(dpcfg_pkg::IDX_INTERP, 32'h84);
    // Request 1 low: only a combined dual link pulls output 0 too
    sync_n <= 2'b01;
    for (int k = 0; k < 3; k++) begin
      wr(dpcfg_pkg::IDX_LINK, {24'h0, lk_s[k]});
      settle();
      chk_val({30'h0, o_sync_out_n}, {30'h0, sy_s[k]});
    end
    wr(dpcfg_pkg::IDX_PAGE, 32'h1);
    wr(dpcfg_pkg::IDX_NCO, 32'h3f);
    rd_chk(dpcfg_pkg::IDX_NCO, 32'h3e);
    wr(dpcfg_pkg::IDX_PAGE, 32'h2);
    rd_chk(dpcfg_pkg::IDX_PAGE, 32'h2);
    rd_chk(dpcfg_pkg::IDX_NCO, 32'h00);
    wr(dpcfg_pkg::IDX_NCO, 32'h14);
    settle();
    chk_val({22'h0, o_nco_en, o_frac_dds_en, o_sideband_low,
      o_switch_mode}, {22'h0, 2'b01, 2'b11, 2'b01, 4'h7});
    wr(dpcfg_pkg::IDX_PAGE, 32'h1);
    for (int m = 0; m < 8; m++) begin
      q0e = m[2] ? 16'h0 - Q0 : Q0;
      q1e = m[2] ? 16'h0 - Q1 : Q1;
      case (m[1:0])
        2'd0: {e0, e1} = {I0, I1};
        2'd1: {e0, e1} = {I0 + I1, q0e + q1e};
        2'd2: {e0, e1} = {I0, q0e};
        default: {e0, e1} = {I0 + I1, 16'h0};
      endcase
      // Main rate above 1x, so the main NCO stays enabled
      // No shift wanted: NCO kept on, tuning word stays zero
      wr(dpcfg_pkg::IDX_NCO, {26'h0, m[1:0], 1'b1, 1'b0, m[2], 1'b0});
      settle();
      chk_val({o_dac0, o_dac1}, {e0, e1});
    end
    wr(dpcfg_pkg::IDX_HOLD, 32'h1);
    settle();
    chk_val({o_dac0, o_dac1}, 32'h0);
    wr(10'h3ff, 32'h5);
    chk_resp(resp, dpcfg_pkg::RESP_SLVERR);
    rd(10'h3ff);
    chk_resp(resp, dpcfg_pkg::RESP_SLVERR);
    chk_val(rdat, 32'h0);
    results();
  end
endmodule : dpcfg_top_test
